// ---- logic/rx_recovery_pkg.sv ----
`default_nettype none
package rx_recovery_pkg;

	// samples per bit and first vote sample, normal and double speed
	localparam logic [4:0] SPB_NORMAL     = 5'h10;
	localparam logic [4:0] SPB_DOUBLE     = 5'h08;
	localparam logic [4:0] VOTE_FIRST_N   = 5'h08;
	localparam logic [4:0] VOTE_FIRST_D   = 5'h04;
	localparam logic [4:0] VOTE_SPAN      = 5'h02;
	localparam logic [4:0] DS_REARM_SMP   = 5'h07;
	localparam logic [4:0] CNT_ONE        = 5'h01;
	localparam logic [2:0] CSZ_NINE       = 3'h7;
	localparam logic [3:0] DATA_BASE      = 4'h5;
	localparam logic [3:0] NINE_BITS      = 4'h9;
	localparam int         RX_BUF_DEPTH   = 2;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_BITS,
		ST_REARM
	} rx_phase_t;

	typedef struct packed {
		logic       overrun;
		logic       par_err;
		logic       frm_err;
		logic [8:0] data;
	} rx_char_t;

	localparam int RX_CHAR_W = $bits(rx_char_t);

	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       last_smp;
		rx_phase_t  phase;
		logic [4:0] cnt;
		logic [3:0] idx;
		logic [2:0] votes;
		logic [8:0] shreg;
		logic       par_acc;
		logic       par_bad;
		logic       hold_vld;
		rx_char_t   hold;
		logic       ovr_pend;
	} rx_state_t;

endpackage : rx_recovery_pkg
`default_nettype wire

// ---- logic/async_uart_rx_recovery.sv ----
// Contract
// R01 - sample input at 16x baud normally, 8x in double speed
// R02 - start search begins on high-to-low edge; first low is sample one
// R03 - validate start on samples 8,9,10 (double speed 4,5,6)
// R04 - two or more high validation samples: reject start, await next edge
// R05 - valid start resynchronises bit timing, afresh for every frame
// R06 - per-bit counter has 16 states normally, 8 in double speed
// R07 - bit value is majority of three centre samples
// R08 - recover data and parity up to first stop bit; ignore second stop
// R09 - first stop bit voted too; zero sets frame error for that frame
// R10 - normal mode rearms right after stop vote; double speed rearms later
// R11 - with filter on, non-address frames are dropped, never buffered
// R12 - marker is first stop bit for 5-8 bits, ninth bit for nine
// R13 - filter acts only on incoming frames, never on transmit
// R14 - nine-bit master sends ninth bit 1 for address, 0 for data
// R15 - slave software clears filter when addressed, sets it after data
// R16 - 5-8 bit senders using the filter send two stop bits
// R17 - filter enable shares register with transmit complete flag; avoid RMW
// R18 - two-character buffer; overrun when full, char waiting, new start
// R19 - double speed changes divisor from 16 to 8, asynchronous only
// R20 - frame, overrun, parity status stored and read with their frame
// R21 - serial input passes a two-stage synchroniser before any sampling
// R22 - after reset or disable, machine idles and drops partial frames
`timescale 1ns/1ps
`default_nettype none

module rx_char_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             nrst_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int CW = $clog2(DEPTH + 1);

	// head always sits in mem[0] so the read side sees flip-flops only
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [CW-1:0]               count;
		logic                        vld;
	} fifo_state_t;

	fifo_state_t   s;
	fifo_state_t   n;
	logic          pop;
	logic          push;
	logic [CW-1:0] base;

	assign in_ready_o  = s.count != CW'(DEPTH);
	assign out_valid_o = s.vld;
	assign out_data_o  = s.mem[0];

	always_comb begin
		n    = s;
		pop  = out_ready_i && s.vld;
		push = in_valid_i && in_ready_o;
		base = s.count - CW'(pop);
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				n.mem[i] = s.mem[i+1];
			end
		end
		if (push) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (CW'(i) == base) begin
					n.mem[i] = in_data_i;
				end
			end
		end
		n.count = base + CW'(push);
		n.vld   = n.count != '0;
		if (flush_i) begin
			n.count = '0;
			n.vld   = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

endmodule : rx_char_fifo

module async_uart_rx_recovery (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic       serial_in_pin_i,
	input  wire logic       sample_tick_i,
	input  wire logic       rx_enable_i,
	input  wire logic       double_speed_sel_i,
	input  wire logic       addr_filter_enable_i,
	input  wire logic [2:0] char_size_sel_i,
	input  wire logic       parity_en_i,
	input  wire logic       parity_odd_i,
	input  wire logic       data_read_i,
	output logic            rx_complete_flag_o,
	output logic      [7:0] data_buffer_reg_o,
	output logic            rx_ninth_bit_o,
	output logic            frame_err_flag_o,
	output logic            overrun_flag_o,
	output logic            parity_err_flag_o
);
	rx_recovery_pkg::rx_state_t s;
	rx_recovery_pkg::rx_state_t n;
	rx_recovery_pkg::rx_char_t  head;

	logic       buf_ready;
	logic       smp;
	logic [4:0] spb;
	logic [4:0] vf;
	logic [4:0] vl;
	logic [4:0] cur;
	logic [3:0] nbits;
	logic [3:0] stop_idx;
	logic       nine;
	logic [2:0] newv;
	logic       maj;
	logic       at_vote;
	logic       fr_done;
	logic       filtered;
	logic       stop_b;
	logic       vstart;
	logic       ovr_ev;

	assign smp      = s.sync2;
	// divisor change: one bit spans 16 or 8 sample ticks
	assign spb      = double_speed_sel_i ? rx_recovery_pkg::SPB_DOUBLE
	                                     : rx_recovery_pkg::SPB_NORMAL; // R19 R01
	assign vf       = double_speed_sel_i ? rx_recovery_pkg::VOTE_FIRST_D
	                                     : rx_recovery_pkg::VOTE_FIRST_N; // R03
	assign vl       = vf + rx_recovery_pkg::VOTE_SPAN;
	assign cur      = s.cnt + rx_recovery_pkg::CNT_ONE;
	assign nine     = char_size_sel_i == rx_recovery_pkg::CSZ_NINE;
	// reserved size codes 4..6 wrap onto 5..7 data bits
	assign nbits    = nine ? rx_recovery_pkg::NINE_BITS
	                       : {2'b00, char_size_sel_i[1:0]}
	                         + rx_recovery_pkg::DATA_BASE;
	assign stop_idx = nbits + {3'b000, parity_en_i}; // R08
	assign newv     = {s.votes[1:0], smp};
	assign maj      = (newv[0] & newv[1]) | (newv[0] & newv[2])
	                | (newv[1] & newv[2]); // R07
	assign at_vote  = sample_tick_i && cur == vl;
	assign stop_b   = maj;
	// ninth bit or first stop bit tells address from data
	assign filtered = addr_filter_enable_i
	                  && !(nine ? s.shreg[8] : stop_b); // R12 R11

	always_comb begin
		n        = s;
		fr_done  = 1'b0;
		vstart   = 1'b0;
		ovr_ev   = 1'b0;
		// first stage feeds only the second
		n.sync1  = serial_in_pin_i; // R21
		n.sync2  = s.sync1; // R21
		if (sample_tick_i) begin
			n.last_smp = smp;
			case (s.phase)
				rx_recovery_pkg::ST_IDLE: begin
					if (!smp && s.last_smp) begin
						n.phase = rx_recovery_pkg::ST_START; // R02
						n.cnt   = rx_recovery_pkg::CNT_ONE; // R02
					end
				end
				rx_recovery_pkg::ST_START: begin
					n.cnt = cur;
					if (cur >= vf && cur <= vl) begin
						n.votes = newv; // R03
					end
					if (cur == vl && maj) begin
						n.phase = rx_recovery_pkg::ST_IDLE; // R04
					end else if (cur == vl) begin
						vstart = 1'b1; // R05
					end
					if (cur == spb) begin
						// bit timing now counts from this frame's own edge
						n.phase   = rx_recovery_pkg::ST_BITS; // R05
						n.cnt     = '0;
						n.idx     = '0;
						n.shreg   = '0;
						n.par_acc = 1'b0;
						n.par_bad = 1'b0;
					end
				end
				rx_recovery_pkg::ST_BITS: begin
					n.cnt = cur; // R06
					if (cur >= vf && cur <= vl) begin
						n.votes = newv;
					end
					if (cur == vl && s.idx == stop_idx) begin
						// second stop bit is never looked at
						fr_done = 1'b1; // R08 R09
						n.phase = double_speed_sel_i
						          ? rx_recovery_pkg::ST_REARM
						          : rx_recovery_pkg::ST_IDLE; // R10
					end else if (cur == vl) begin
						if (s.idx < nbits) begin
							n.shreg[s.idx] = maj; // R07
							n.par_acc      = s.par_acc ^ maj;
						end else begin
							n.par_bad = parity_en_i
							            && ((s.par_acc ^ maj) != parity_odd_i);
						end
						n.idx = s.idx + 4'h1; // R08
					end
					if (cur == spb) begin
						n.cnt = '0; // R06
					end
				end
				rx_recovery_pkg::ST_REARM: begin
					// double speed: hold off a new edge past the stop vote
					n.cnt = cur;
					if (cur >= rx_recovery_pkg::DS_REARM_SMP) begin
						n.phase = rx_recovery_pkg::ST_IDLE; // R10
					end
				end
				default: begin
					n.phase = rx_recovery_pkg::ST_IDLE;
				end
			endcase
		end
		if (s.hold_vld && buf_ready) begin
			n.hold_vld = 1'b0;
		end
		// full buffer and a waiting character: the new start overwrites it
		if (vstart && s.hold_vld && !buf_ready) begin
			ovr_ev     = 1'b1; // R18
			n.hold_vld = 1'b0; // R18
		end
		// filter only gates received frames; the enable is a plain level
		// here, so no read-modify-write path can touch transmit status
		if (fr_done && !filtered) begin // R11 R13 R17
			n.hold_vld     = 1'b1;
			n.hold.data    = s.shreg;
			n.hold.frm_err = !stop_b; // R09 R20
			n.hold.par_err = s.par_bad; // R20
			n.hold.overrun = s.ovr_pend; // R20
			n.ovr_pend     = 1'b0;
		end
		if (ovr_ev) begin
			n.ovr_pend = 1'b1; // R18
		end
		if (!rx_enable_i) begin
			n.phase    = rx_recovery_pkg::ST_IDLE; // R22
			n.cnt      = '0;
			n.hold_vld = 1'b0; // R22
			n.ovr_pend = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			// idle line level, so an input held low out of reset is seen as a falling edge
			s          <= '0;
			s.sync1    <= 1'b1;
			s.sync2    <= 1'b1;
			s.last_smp <= 1'b1;
		end else begin
			s <= n;
		end
	end

	rx_char_fifo #(
		.WIDTH (rx_recovery_pkg::RX_CHAR_W),
		.DEPTH (rx_recovery_pkg::RX_BUF_DEPTH)
	) u_buf (
		.clk_i       (mclk_i),
		.nrst_i      (nrst_i),
		.flush_i     (!rx_enable_i), // R22
		.in_valid_i  (s.hold_vld),
		.in_ready_o  (buf_ready),
		.in_data_i   (s.hold),
		.out_valid_o (rx_complete_flag_o),
		.out_ready_i (data_read_i),
		.out_data_o  (head)
	);

	// status travels with its character and leaves with it
	assign data_buffer_reg_o = head.data[7:0]; // R20
	assign rx_ninth_bit_o    = head.data[8];
	assign frame_err_flag_o  = head.frm_err; // R20
	assign overrun_flag_o    = head.overrun; // R20
	assign parity_err_flag_o = head.par_err; // R20

	default clocking cb @(posedge mclk_i);
	endclocking

	default disable iff (!nrst_i);

	sequence s_fall;
		rx_enable_i && sample_tick_i && s.phase == rx_recovery_pkg::ST_IDLE
		&& !s.sync2 && s.last_smp;
	endsequence

	sequence s_frame_end;
		rx_enable_i && fr_done;
	endsequence

	property p_fall_start;
		s_fall |=> s.phase == rx_recovery_pkg::ST_START
		           && s.cnt == 5'h01;
	endproperty
	a_fall_start: assert property (p_fall_start) // R02
		else $error("edge did not start sample one");

	property p_noise;
		rx_enable_i && s.phase == rx_recovery_pkg::ST_START && at_vote && maj
		|=> s.phase == rx_recovery_pkg::ST_IDLE;
	endproperty
	a_noise: assert property (p_noise) // R04
		else $error("noise start was not rejected");

	property p_bit_wrap;
		rx_enable_i && s.phase == rx_recovery_pkg::ST_BITS && sample_tick_i
		&& cur == spb |=> s.cnt == 5'h00 && $past(s.cnt) == spb - 5'h01;
	endproperty
	a_bit_wrap: assert property (p_bit_wrap) // R06
		else $error("bit counter did not wrap at its length");

	property p_disable;
		!rx_enable_i |=> s.phase == rx_recovery_pkg::ST_IDLE
		                 && !s.hold_vld && !rx_complete_flag_o;
	endproperty
	a_disable: assert property (p_disable) // R22
		else $error("disable left frame or buffer content");

	property p_filter;
		s_frame_end ##0 filtered |=> !s.hold_vld;
	endproperty
	a_filter: assert property (p_filter) // R11
		else $error("filtered frame reached the buffer path");

	property p_frame_err;
		s_frame_end ##0 !filtered
		|=> s.hold_vld && s.hold.frm_err == !$past(stop_b);
	endproperty
	a_frame_err: assert property (p_frame_err) // R09
		else $error("frame error does not match stop bit");

	property p_overrun;
		rx_enable_i && ovr_ev |=> s.ovr_pend && !s.hold_vld;
	endproperty
	a_overrun: assert property (p_overrun) // R18
		else $error("overrun not recorded");

	property p_rearm;
		s_frame_end ##0 !double_speed_sel_i
		|=> s.phase == rx_recovery_pkg::ST_IDLE;
	endproperty
	a_rearm: assert property (p_rearm) // R10
		else $error("normal mode did not rearm after stop vote");

endmodule : async_uart_rx_recovery
`default_nettype wire

// ---- testbench/serial_tx_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model (
	input  wire logic mclk_i,
	input  wire logic tick_i,
	input  wire logic ds_i,
	output logic      line_o
);

	// line idles at mark level between frames
	initial line_o = 1'b1;

	// bit time is counted in receiver ticks, so no baud drift is modelled
	task automatic hold_ticks(input int n);
		repeat (n) begin
			do @(posedge mclk_i); while (tick_i !== 1'b1);
		end
		@(negedge mclk_i);
	endtask : hold_ticks

	// start bit, then n bits lsb first; marker and stops travel in bits
	task automatic send(input logic [11:0] bits, input int n);
		int spb;
		spb = ds_i ? 8 : 16;
		// one clock of idle so back-to-back frames never redrive the line
		@(negedge mclk_i);
		line_o = 1'b0;
		hold_ticks(spb);
		for (int i = 0; i < n; i++) begin
			line_o = bits[i];
			hold_ticks(spb);
		end
		line_o = 1'b1;
	endtask : send

	task automatic glitch(input int n);
		line_o = 1'b0;
		hold_ticks(n);
		line_o = 1'b1;
	endtask : glitch

endmodule : serial_tx_model
`default_nettype wire

// ---- testbench/async_uart_rx_recovery_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module async_uart_rx_recovery_tb_top;

	logic       mclk_i  = 1'b0;
	logic       nrst_i  = 1'b0;
	logic       tick    = 1'b0;
	logic       ser;
	logic       rx_en   = 1'b1;
	logic       ds      = 1'b0;
	logic       filt    = 1'b0;
	logic [2:0] csz     = 3'h3;
	logic       par_en  = 1'b0;
	logic       par_odd = 1'b0;
	logic       rd      = 1'b0;
	logic       rxc;
	logic [7:0] dat;
	logic       b9;
	logic       fe;
	logic       ov;
	logic       pe;
	int         bad_count = 0;
	int         compares  = 0;

	always #20 mclk_i = ~mclk_i;
	always @(negedge mclk_i) tick <= ~tick;

	serial_tx_model i_tx (
		.mclk_i (mclk_i),
		.tick_i (tick),
		.ds_i   (ds),
		.line_o (ser)
	);

	async_uart_rx_recovery i_dut (
		.mclk_i               (mclk_i),
		.nrst_i               (nrst_i),
		.serial_in_pin_i      (ser),
		.sample_tick_i        (tick),
		.rx_enable_i          (rx_en),
		.double_speed_sel_i   (ds),
		.addr_filter_enable_i (filt),
		.char_size_sel_i      (csz),
		.parity_en_i          (par_en),
		.parity_odd_i         (par_odd),
		.data_read_i          (rd),
		.rx_complete_flag_o   (rxc),
		.data_buffer_reg_o    (dat),
		.rx_ninth_bit_o       (b9),
		.frame_err_flag_o     (fe),
		.overrun_flag_o       (ov),
		.parity_err_flag_o    (pe)
	);

	task automatic complete_run();
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk9

	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk1

	task automatic wait_rxc();
		int n;
		n = 0;
		while (rxc !== 1'b1 && n < 4000) begin
			@(negedge mclk_i);
			n++;
		end
		if (rxc !== 1'b1) begin
			bad_count++;
			complete_run();
		end
	endtask : wait_rxc

	// f holds frame, parity and overrun flags in that order
	task automatic take(input logic [8:0] d, input logic [2:0] f);
		wait_rxc();
		chk9({b9, dat}, d);
		chk1(fe, f[2]);
		chk1(pe, f[1]);
		chk1(ov, f[0]);
		rd = 1'b1;
		@(negedge mclk_i);
		rd = 1'b0;
		@(negedge mclk_i);
	endtask : take

	initial begin
		repeat (10) @(negedge mclk_i);
		nrst_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		i_tx.send(12'h1A5, 9);
		take(9'h0A5, 3'h0);
		i_tx.send(12'h05A, 9);
		take(9'h05A, 3'h4);
		i_tx.glitch(3);
		repeat (400) @(negedge mclk_i);
		chk1(rxc, 1'b0);
		i_tx.send(12'h13C, 9);
		take(9'h03C, 3'h0);
		par_en = 1'b1;
		i_tx.send(12'h33C, 10);
		take(9'h03C, 3'h2);
		par_odd = 1'b1;
		i_tx.send(12'h33C, 10);
		take(9'h03C, 3'h0);
		par_en = 1'b0;
		ds = 1'b1;
		i_tx.send(12'h1C3, 9);
		i_tx.send(12'h13E, 9);
		take(9'h0C3, 3'h0);
		take(9'h03E, 3'h0);
		ds = 1'b0;
		csz = 3'h7;
		filt = 1'b1;
		i_tx.send(12'h255, 10);
		i_tx.send(12'h3AA, 10);
		take(9'h1AA, 3'h0);
		filt = 1'b0;
		i_tx.send(12'h255, 10);
		take(9'h055, 3'h0);
		csz = 3'h0;
		filt = 1'b1;
		i_tx.send(12'h055, 7);
		i_tx.send(12'h06A, 7);
		take(9'h00A, 3'h0);
		filt = 1'b0;
		// seven-bit frame: the stop bit must not leak into data bit 7
		csz = 3'h2;
		i_tx.send(12'h0D5, 8);
		take(9'h055, 3'h0);
		csz = 3'h3;
		// four back to back frames with no reads: the third is lost
		i_tx.send(12'h111, 9);
		i_tx.send(12'h122, 9);
		i_tx.send(12'h133, 9);
		i_tx.send(12'h144, 9);
		take(9'h011, 3'h0);
		take(9'h022, 3'h0);
		take(9'h044, 3'h1);
		i_tx.send(12'h177, 9);
		wait_rxc();
		rx_en = 1'b0;
		repeat (3) @(negedge mclk_i);
		chk1(rxc, 1'b0);
		rx_en = 1'b1;
		repeat (4) @(negedge mclk_i);
		i_tx.send(12'h1E1, 9);
		take(9'h0E1, 3'h0);
		complete_run();
	end

endmodule : async_uart_rx_recovery_tb_top
`default_nettype wire
